// *** cit_consts.svh ***
// Offsets, field positions, reset values and counts of the global register bank.
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH
`define CIT_OFS_CHIP_ID_LO   8'h04
`define CIT_OFS_CHIP_ID_HI   8'h05
`define CIT_OFS_SPEED_GRADE  8'h06
`define CIT_OFS_CORE_SEL     8'h08
`define CIT_OFS_SCRATCH      8'h0a
`define CIT_OFS_IF_REV       8'h0b
`define CIT_OFS_MAKER_LO     8'h0c
`define CIT_OFS_MAKER_HI     8'h0d
`define CIT_OFS_STROBE       8'h0f
`define CIT_BIT_CORE_A       0
`define CIT_BIT_CORE_B       1
`define CIT_BIT_STROBE       0
`define CIT_SPEED_LSB        4
`define CIT_RST_CORE_SEL     2'h3
`define CIT_RST_SCRATCH      8'h00
`define CIT_RST_SPEED        4'h0
`define CIT_COPY_CYCLES      4
`endif

// *** cit_pkg.sv ***
// Types shared by the global register bank files.
`default_nettype none
package cit_pkg;
  // Copy sequencer states, Gray coded along the path.
  typedef enum logic [1:0]
  {
    CIT_IDLE = 2'b00,
    CIT_COPY = 2'b01,
    CIT_DONE = 2'b11
  } cit_copy_state_t;
endpackage : cit_pkg
`default_nettype wire

// *** cit_shadow_bank.sv ***
// Master and slave copy store for shadowed settings.
`timescale 1ns/100ps
`default_nettype none
module cit_shadow_bank #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             mst_we,
  input  wire logic [AW-1:0]    mst_addr,
  input  wire logic [WIDTH-1:0] mst_wdata,
  input  wire logic             copy_en,
  input  wire logic [AW-1:0]    copy_addr,
  input  wire logic [AW-1:0]    slv_addr,
  output logic      [WIDTH-1:0] slv_rdata
);
  // Refuse an address width that cannot reach every entry.
  if ((1 << AW) < DEPTH) begin : g_chk
    $error("cit_shadow_bank: AW too small for DEPTH");
  end
  logic [WIDTH-1:0] mst_mem [DEPTH];   // Staged values software writes.
  logic [WIDTH-1:0] slv_mem [DEPTH];   // Active values the datapath uses.
  logic [WIDTH-1:0] rd_q;              // Registered read data.

  // Master writes, slave loads only on copy, read data registered.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= '0;
    end
    else
    begin
      rd_q <= slv_mem[slv_addr];
    end
  end

  // Memory arrays carry no reset.
  always_ff @(posedge clk_sys)
  begin
    if (mst_we)
    begin
      mst_mem[mst_addr] <= mst_wdata;
    end
    if (copy_en)
    begin
      slv_mem[copy_addr] <= mst_mem[copy_addr]; // [RQ7]
    end
  end

  assign slv_rdata = rd_q;
endmodule : cit_shadow_bank
`default_nettype wire

// *** cit_global_regs.sv ***
// Global register bank: identity, core select, scratch and copy strobe.
//
// What this block does
// [RQ1] Core select bit 1 gates core B.
// [RQ2] Core select bit 0 gates core A.
// [RQ3] Free eight-bit scratch register, read back.
// [RQ4] Strobe loads mixer phase settings in sync mode.
// [RQ5] Strobe also loads filter coefficients.
// [RQ6] Strobe clears itself after copy completes.
// [RQ7] Slave copies change only on strobe write.
// [RQ8] Identity registers fixed; writes ignored.
`timescale 1ns/100ps
`default_nettype none
`include "cit_consts.svh"
module cit_global_regs #(
  parameter logic [7:0] CHIP_ID_LO  = 8'h5a, // Arbitrary value.
  parameter logic [7:0] CHIP_ID_HI  = 8'h00, // Arbitrary value.
  parameter logic [7:0] IF_REV      = 8'h02, // Arbitrary value.
  parameter logic [7:0] MAKER_LO    = 8'h3c, // Arbitrary value.
  parameter logic [7:0] MAKER_HI    = 8'h07, // Arbitrary value.
  parameter logic [3:0] SPEED_GRADE = `CIT_RST_SPEED,
  parameter int         COEF_DEPTH  = 8,
  parameter int         COEF_AW     = 3
) (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic               cmd_valid,
  output logic                    core_a_cmd,
  output logic                    core_b_cmd,
  input  wire logic               mixer_phase_sync_mode,
  output logic                    mixer_phase_load,
  input  wire logic               filt_mst_we,
  input  wire logic [COEF_AW-1:0] filt_mst_addr,
  input  wire logic [31:0]        filt_mst_wdata,
  input  wire logic [COEF_AW-1:0] filt_slv_addr,
  output logic      [31:0]        programmable_filter_coef
);
  // Refuse a coefficient store the address cannot cover.
  // A zero depth would leave the copy walk without a last word to stop on.
  if (COEF_DEPTH < 1 || (1 << COEF_AW) < COEF_DEPTH) begin : g_chk
    $error("cit_global_regs: bad COEF_DEPTH or COEF_AW");
  end

  // Index of the final coefficient word of a copy walk.
  localparam logic [COEF_AW-1:0] LAST = COEF_AW'(COEF_DEPTH - 1);

  // Returns true when a write hits the given offset.
  // Shared by every write decode so the offsets match exactly.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Software-visible state and its next values.
  logic [1:0]              core_sel_q;   // Per-core command gates.
  logic [1:0]              core_sel_d;
  logic [7:0]              scratch_q;    // Debug scratch byte.
  logic [7:0]              scratch_d;
  logic [7:0]              rdata_q;      // Registered read data.
  logic [7:0]              rdata_d;
  // Command pulses toward the two cores, one cycle after the command.
  logic                    core_a_q;     // Registered core A gate pulse.
  logic                    core_b_q;     // Registered core B gate pulse.
  logic                    mix_load_q;   // Phase load pulse.
  logic                    mix_load_d;
  // Copy sequencer, its word index and the flags derived from it.
  cit_pkg::cit_copy_state_t st_q;        // Copy sequencer state.
  cit_pkg::cit_copy_state_t st_d;
  logic [COEF_AW-1:0]      idx_q;        // Coefficient copy index.
  logic [COEF_AW-1:0]      idx_d;
  logic                    strobe;       // Strobe bit as seen by reads.
  logic                    copy_en;      // Copy one coefficient word.

  // Strobe reads 1 from the write until the copy is done.
  // Deriving the flag from the state means it can never be left set.
  assign strobe  = (st_q != cit_pkg::CIT_IDLE); // [RQ6]
  assign copy_en = (st_q == cit_pkg::CIT_COPY); // [RQ5]

  // Next values of the writable registers and the sequencer.
  always_comb
  begin
    // Every value but the phase load holds unless a write or the sequencer moves it.
    core_sel_d = core_sel_q;
    scratch_d  = scratch_q;
    st_d       = st_q;
    idx_d      = idx_q;
    // The phase load is a one-cycle pulse, so it defaults low.
    mix_load_d = 1'b0;
    if (reg_wr && hit(reg_addr, `CIT_OFS_CORE_SEL))
    begin
      // Only the two gate bits are stored; the reserved bits read zero.
      core_sel_d = reg_wdata[1:0]; // [RQ1] [RQ2]
    end
    if (reg_wr && hit(reg_addr, `CIT_OFS_SCRATCH))
    begin
      // The scratch byte feeds nothing but the read multiplexer.
      scratch_d = reg_wdata; // [RQ3]
    end
    // Identity offsets have no write path at all. [RQ8]
    // Unmapped offsets have none either, so such writes vanish.
    case (st_q)
      cit_pkg::CIT_IDLE:
      begin
        // A write of 1 starts the master-to-slave copy.
        // A write of 0 leaves the bank as it is.
        // The phase load follows the mode bit as it stands at that write.
        if (reg_wr && hit(reg_addr, `CIT_OFS_STROBE)
            && reg_wdata[`CIT_BIT_STROBE])
        begin
          st_d       = cit_pkg::CIT_COPY; // [RQ7]
          idx_d      = '0;
          mix_load_d = mixer_phase_sync_mode; // [RQ4]
        end
      end
      cit_pkg::CIT_COPY:
      begin
        // Walk every coefficient word once.
        // Each cycle here copies the word at the current index.
        // A strobe write now is ignored; the copy already runs.
        if (idx_q == LAST)
        begin
          st_d = cit_pkg::CIT_DONE;
        end
        else
        begin
          idx_d = idx_q + 1'b1;
        end
      end
      cit_pkg::CIT_DONE:
      begin
        // Last word is now settled, so the strobe may clear.
        // Polling software thus sees 1 until the whole set is active.
        st_d = cit_pkg::CIT_IDLE; // [RQ6]
      end
      default:
      begin
        // An unused code falls back to idle instead of hanging busy.
        st_d = cit_pkg::CIT_IDLE;
      end
    endcase
  end

  // Read data multiplexer; unmapped offsets read zero.
  always_comb
  begin
    // Read data is captured on the read strobe and then held,
    // so a slow host may fetch it at any later time.
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      case (reg_addr)
        `CIT_OFS_CHIP_ID_LO:  rdata_d = CHIP_ID_LO; // [RQ8]
        `CIT_OFS_CHIP_ID_HI:  rdata_d = CHIP_ID_HI;
        `CIT_OFS_SPEED_GRADE: rdata_d = {SPEED_GRADE, 4'h0};
        `CIT_OFS_CORE_SEL:    rdata_d = {6'h00, core_sel_q};
        `CIT_OFS_SCRATCH:     rdata_d = scratch_q; // [RQ3]
        `CIT_OFS_IF_REV:      rdata_d = IF_REV;
        `CIT_OFS_MAKER_LO:    rdata_d = MAKER_LO;
        `CIT_OFS_MAKER_HI:    rdata_d = MAKER_HI;
        `CIT_OFS_STROBE:      rdata_d = {7'h00, strobe}; // [RQ6]
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  // Register all state; core gates act on each command pulse.
  // The gates use the select bits as they stand at the command edge,
  // so a select write and a command in one cycle use the old selection.
  // Reset puts every register to its reset value at once.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_sel_q <= `CIT_RST_CORE_SEL;
      scratch_q  <= `CIT_RST_SCRATCH;
      rdata_q    <= 8'h00;
      core_a_q   <= 1'b0;
      core_b_q   <= 1'b0;
      mix_load_q <= 1'b0;
      st_q       <= cit_pkg::CIT_IDLE;
      idx_q      <= '0;
    end
    else
    begin
      core_sel_q <= core_sel_d;
      scratch_q  <= scratch_d;
      rdata_q    <= rdata_d;
      core_a_q   <= cmd_valid & core_sel_q[`CIT_BIT_CORE_A]; // [RQ2]
      core_b_q   <= cmd_valid & core_sel_q[`CIT_BIT_CORE_B]; // [RQ1]
      mix_load_q <= mix_load_d;
      st_q       <= st_d;
      idx_q      <= idx_d;
    end
  end

  // Outputs come straight from registers, with no logic after them.
  assign reg_rdata        = rdata_q;
  assign core_a_cmd       = core_a_q;
  assign core_b_cmd       = core_b_q;
  assign mixer_phase_load = mix_load_q;

  // Coefficient masters and slaves; slaves change only during copy.
  // The active word reaches the filter one cycle after its address.
  cit_shadow_bank #(
    .WIDTH (32),
    .DEPTH (COEF_DEPTH),
    .AW    (COEF_AW)
  ) u_coef (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .mst_we    (filt_mst_we),
    .mst_addr  (filt_mst_addr),
    .mst_wdata (filt_mst_wdata),
    .copy_en   (copy_en),
    .copy_addr (idx_q),
    .slv_addr  (filt_slv_addr),
    .slv_rdata (programmable_filter_coef)
  );
endmodule : cit_global_regs
`default_nettype wire

// *** cit_global_regs_sva.sv ***
// Checker of the global register bank ports.
`timescale 1ns/100ps
`default_nettype none
module cit_global_regs_chk #(
  parameter logic [7:0] CHIP_ID_LO  = 8'h00,
  parameter logic [7:0] CHIP_ID_HI  = 8'h00,
  parameter logic [7:0] IF_REV      = 8'h00,
  parameter logic [7:0] MAKER_LO    = 8'h00,
  parameter logic [7:0] MAKER_HI    = 8'h00,
  parameter logic [3:0] SPEED_GRADE = 4'h0,
  parameter int         COEF_DEPTH  = 8,
  parameter int         COEF_AW     = 3
) (
  input wire logic               clk_sys,
  input wire logic               arst_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  input wire logic               cmd_valid,
  input wire logic               core_a_cmd,
  input wire logic               core_b_cmd,
  input wire logic               mixer_phase_sync_mode,
  input wire logic               mixer_phase_load,
  input wire logic               filt_mst_we,
  input wire logic [COEF_AW-1:0] filt_mst_addr,
  input wire logic [31:0]        filt_mst_wdata,
  input wire logic [COEF_AW-1:0] filt_slv_addr,
  input wire logic [31:0]        programmable_filter_coef
);
  logic [1:0] sel_q; // Mirrored core select.
  logic [7:0] scr_q; // Mirrored scratch byte.
  logic [4:0] cnt_q; // Cycles left until the strobe reads idle.
  logic       cpy_q; // Set once a copy has filled the active set.
  logic [7:0] exp_v; // Expected read data at the current address.
  logic       go;    // Strobe write that starts a copy.
  assign go = reg_wr && reg_addr == 8'h0f && reg_wdata[0] && cnt_q < 5'h2;
  // Mirror of the writable state, updated by accepted writes.
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      sel_q <= 2'h3;
      scr_q <= 8'h00;
      cnt_q <= 5'h00;
      cpy_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h08) sel_q <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 8'h0a) scr_q <= reg_wdata;
      cnt_q <= go ? 5'(COEF_DEPTH + 2) : cnt_q - 5'(cnt_q != 5'h00);
      cpy_q <= cpy_q | (cnt_q == 5'h01);
    end
  // Expected read value; unmapped places read zero.
  always_comb
    case (reg_addr)
      8'h04:   exp_v = CHIP_ID_LO;
      8'h05:   exp_v = CHIP_ID_HI;
      8'h06:   exp_v = {SPEED_GRADE, 4'h0};
      8'h08:   exp_v = {6'h00, sel_q};
      8'h0a:   exp_v = scr_q;
      8'h0b:   exp_v = IF_REV;
      8'h0c:   exp_v = MAKER_LO;
      8'h0d:   exp_v = MAKER_HI;
      8'h0f:   exp_v = {7'h00, cnt_q > 5'h01};
      default: exp_v = 8'h00;
    endcase
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_core_a_gate: assert property (
    core_a_cmd == $past(cmd_valid & sel_q[0])) else $error("core A gate");
  a_core_b_gate: assert property (
    core_b_cmd == $past(cmd_valid & sel_q[1])) else $error("core B gate");
  a_sel_read: assert property (
    reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(exp_v))
    else $error("core select readback");
  a_scratch_back: assert property (
    reg_rd && reg_addr == 8'h0a |=> reg_rdata == $past(exp_v))
    else $error("scratch readback");
  a_phase_load: assert property (
    mixer_phase_load == $past(go && mixer_phase_sync_mode))
    else $error("phase load pulse");
  a_strobe_busy: assert property (
    reg_rd && reg_addr == 8'h0f |=> reg_rdata == $past(exp_v))
    else $error("strobe busy flag");
  a_slave_hold: assert property (
    cpy_q && cnt_q == 5'h00 && $past(cnt_q) == 5'h00 && $stable(filt_slv_addr)
    |=> $stable(programmable_filter_coef)) else $error("active set moved");
  a_ident_fixed: assert property (
    reg_rd && reg_addr inside {8'h04, 8'h05, 8'h06, 8'h0b, 8'h0c, 8'h0d}
    |=> reg_rdata == $past(exp_v)) else $error("fixed byte changed");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule : cit_global_regs_chk
bind cit_global_regs cit_global_regs_chk #(
  .CHIP_ID_LO(CHIP_ID_LO), .CHIP_ID_HI(CHIP_ID_HI), .IF_REV(IF_REV),
  .MAKER_LO(MAKER_LO), .MAKER_HI(MAKER_HI), .SPEED_GRADE(SPEED_GRADE),
  .COEF_DEPTH(COEF_DEPTH), .COEF_AW(COEF_AW)
) u_chk (.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .cmd_valid, .core_a_cmd, .core_b_cmd, .mixer_phase_sync_mode,
  .mixer_phase_load, .filt_mst_we, .filt_mst_addr, .filt_mst_wdata,
  .filt_slv_addr, .programmable_filter_coef);
`default_nettype wire

// *** cit_host_model.sv ***
// Host model that drives the register port of the bank.
`timescale 1ns/100ps
`default_nettype none
module cit_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Byte write; released lines show the inverse so stale data is not seen.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // Byte read; data is taken once the read edge's update has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : cit_host_model
`default_nettype wire

// *** cit_global_regs_tb_top.sv ***
// Testbench of the global register bank.
`timescale 1ns/100ps
`default_nettype none
module cit_global_regs_tb_top;
  logic        clk_sys = 1'b0, arst_n = 1'b0, filt_mst_we = 1'b0;
  logic        cmd_valid = 1'b0, mixer_phase_sync_mode = 1'b0;
  logic [2:0]  filt_mst_addr = 3'h0, filt_slv_addr = 3'h0;
  logic [31:0] filt_mst_wdata = 32'h0, programmable_filter_coef;
  logic        reg_wr, reg_rd, core_a_cmd, core_b_cmd, mixer_phase_load;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  int          error_cnt = 0, tests_run = 0;
  initial forever #5 clk_sys = ~clk_sys;
  cit_host_model host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  // Identity values are arbitrary.
  cit_global_regs #(.CHIP_ID_LO(8'h11), .CHIP_ID_HI(8'h22), .IF_REV(8'h33),
    .MAKER_LO(8'h44), .MAKER_HI(8'h55)) dut (.clk_sys, .arst_n, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cmd_valid, .core_a_cmd,
    .core_b_cmd, .mixer_phase_sync_mode, .mixer_phase_load, .filt_mst_we,
    .filt_mst_addr, .filt_mst_wdata, .filt_slv_addr,
    .programmable_filter_coef);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // Reset value, then back-to-back writes; the last one wins.
  task automatic t_scratch();
    logic [7:0] d;
    host.rd(8'h0a, d);
    chk(d, 8'h00);
    host.wr(8'h0a, 8'ha5);
    host.wr(8'h0a, 8'h5a);
    host.rd(8'h0a, d);
    chk(d, 8'h5a);
  endtask : t_scratch
  // Every core select code gates one command pulse.
  task automatic t_sel();
    logic [7:0] d;
    host.rd(8'h08, d);
    chk(d, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      host.wr(8'h08, 8'(s));
      @(posedge clk_sys) cmd_valid <= 1'b1;
      @(posedge clk_sys) cmd_valid <= 1'b0;
      #1 chk(core_a_cmd, s[0]);
      chk(core_b_cmd, s[1]);
    end
    host.wr(8'h08, 8'hff);
    host.rd(8'h08, d);
    chk(d, 8'h03);
  endtask : t_sel
  // Fixed bytes ignore writes; unmapped places read zero.
  task automatic t_ident();
    logic [7:0] a [8] = '{8'h04, 8'h05, 8'h06, 8'h0b, 8'h0c, 8'h0d, 8'h07,
      8'h10};
    logic [7:0] e [8] = '{8'h11, 8'h22, 8'h00, 8'h33, 8'h44, 8'h55, 8'h00,
      8'h00};
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(a[i], 8'hff);
      host.rd(a[i], d);
      chk(d, e[i]);
    end
  endtask : t_ident
  // Reads one active coefficient and compares it.
  task automatic slv(input int i, input logic [31:0] exp);
    @(posedge clk_sys) filt_slv_addr <= 3'(i);
    @(posedge clk_sys);
    #1 chk(programmable_filter_coef, exp);
  endtask : slv
  // Stage masters, fire the strobe, poll until clear, check the active set.
  task automatic t_copy(input logic m, input logic [31:0] b, old);
    logic [7:0] d;
    int         n;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      filt_mst_we    <= 1'b1;
      filt_mst_addr  <= 3'(i);
      filt_mst_wdata <= b + i;
      @(posedge clk_sys) filt_mst_we <= 1'b0;
    end
    if (!m) slv(3, old + 3);
    @(posedge clk_sys) mixer_phase_sync_mode <= m;
    // A strobe write of 0 must neither load phases nor start a copy.
    host.wr(8'h0f, 8'h00);
    #1 chk(mixer_phase_load, 1'b0);
    host.rd(8'h0f, d);
    chk(d, 8'h00);
    if (!m) slv(3, old + 3);
    host.wr(8'h0f, 8'h01);
    #1 chk(mixer_phase_load, m);
    n = 0;
    do
    begin
      host.rd(8'h0f, d);
      n++;
      if (n == 1) chk(d, 8'h01);
    end
    while (d !== 8'h00 && n < 20);
    chk(n > 1, 1'b1);
    if (d !== 8'h00)
    begin
      error_cnt++;
      results();
    end
    for (int i = 0; i < 8; i++) slv(i, b + i);
  endtask : t_copy
  // Reset in mid-copy returns every writable register to its reset value.
  task automatic t_reset();
    logic [7:0] d;
    host.wr(8'h0a, 8'h77);
    host.wr(8'h08, 8'h00);
    host.wr(8'h0f, 8'h01);
    @(posedge clk_sys) arst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    host.rd(8'h0f, d);
    chk(d, 8'h00);
    host.rd(8'h08, d);
    chk(d, 8'h03);
    host.rd(8'h0a, d);
    chk(d, 8'h00);
  endtask : t_reset
  initial
  begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_scratch();
    t_sel();
    t_ident();
    t_reset();
    t_copy(1'b1, 32'h1000_0000, 32'h0);
    t_copy(1'b0, 32'h2000_0000, 32'h1000_0000);
    results();
  end
endmodule : cit_global_regs_tb_top
`default_nettype wire
